// *** dv/rmo_mode_ctrl_assertions.sv ***
// Port checker for the mode and output control block.
// Assumes inputs held for 15 cycles have passed the pin synchroniser.
`timescale 1ns/1ns
`default_nettype none
module rmo_mode_ctrl_assertions
  import rmo_pkg::*;
(
  // Clock, reset and pins
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic busWidthSelect,
  input wire logic processingEnablePin,
  input wire logic asyncTransportModePin,
  input wire logic rateSelect,
  input wire logic masterModePin,
  input wire logic testModePin,
  input wire logic videoModePinIn,
  // Core and register side
  input wire logic coreLockedSmpte,
  input wire logic coreLockedAsi,
  input wire logic [WORD_W-1:0] chromaWordIn,
  input wire logic [2*WORD_W-1:0] rawDataIn,
  input wire logic regWr,
  input wire logic regRd,
  // Outputs
  input wire logic videoModePinOut,
  input wire logic videoModePinOe,
  input wire logic descrambleEnable,
  input wire logic [FEAT_N-1:0] featureEnable,
  input wire logic [WORD_W-1:0] doutSecond,
  input wire logic doutOe,
  input wire logic serialLoopOutputOe,
  input wire logic testSeqReset_n,
  input wire logic [DATA_W-1:0] regRdata
);
  // ==========================================================
  // Settle counter
  // Pin-driven outputs are judged only once inputs stop moving, so sync latency never matters
  logic [39:0] inVec;
  logic [39:0] inVec_r;
  logic [3:0] quiet_r;
  logic [3:0] quiet_nxt;
  logic vid;
  assign inVec = {busWidthSelect, processingEnablePin, asyncTransportModePin, rateSelect,
    masterModePin, testModePin, videoModePinIn, coreLockedSmpte, coreLockedAsi, regWr,
    chromaWordIn, rawDataIn};
  assign vid = masterModePin ? coreLockedSmpte : videoModePinIn;
  always_comb
  begin
    quiet_nxt = (quiet_r == 4'hf) ? quiet_r : quiet_r + 4'h1;
    if (inVec != inVec_r)
      quiet_nxt = 4'h0;
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      inVec_r <= '0;
      quiet_r <= 4'h0;
    end
    else
    begin
      inVec_r <= inVec;
      quiet_r <= quiet_nxt;
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Inputs that moved at this very edge must not meet outputs launched before it
  sequence st_s(c);
    quiet_r == 4'hf && inVec == inVec_r && c;
  endsequence
  width10_low_a: assert property (st_s(!busWidthSelect) |-> doutSecond == 10'h000)
    else $error("second word not low in ten bit mode");
  chroma_out_a: assert property (st_s(busWidthSelect && vid && !asyncTransportModePin)
    |-> doutSecond == chromaWordIn) else $error("second word not chroma");
  thru_out_a: assert property (st_s(busWidthSelect && !vid && !asyncTransportModePin)
    |-> doutSecond == rawDataIn[2*WORD_W-1:WORD_W]) else $error("second word not raw");
  asi_low_a: assert property (st_s(busWidthSelect && asyncTransportModePin)
    |-> doutSecond == 10'h000) else $error("second word not low in transport mode");
  feat_off_a: assert property (st_s(!processingEnablePin) |-> featureEnable == 6'h00)
    else $error("features on with enable low");
  slave_off_a: assert property (st_s(!masterModePin && !videoModePinIn)
    |-> !descrambleEnable && featureEnable == 6'h00) else $error("video path on");
  master_drive_a: assert property (st_s(masterModePin)
    |-> videoModePinOe && videoModePinOut == coreLockedSmpte) else $error("mode pin wrong");
  slave_release_a: assert property (st_s(!masterModePin) |-> !videoModePinOe)
    else $error("mode pin driven in slave");
  test_follow_a: assert property (st_s(1'h1) |-> testSeqReset_n == testModePin)
    else $error("test sequence reset wrong");
  rd_idle_a: assert property (!regRd |=> regRdata == 16'h0000)
    else $error("read data outside read slot");
  reset_quiet_a: assert property (disable iff (1'h0) !arst_n |->
    !doutOe && !videoModePinOe && !serialLoopOutputOe && !testSeqReset_n)
    else $error("outputs driven in reset");
endmodule
bind rmo_mode_ctrl rmo_mode_ctrl_assertions i_chk (
  .mclk, .arst_n, .busWidthSelect, .processingEnablePin, .asyncTransportModePin,
  .rateSelect, .masterModePin, .testModePin, .videoModePinIn, .coreLockedSmpte,
  .coreLockedAsi, .chromaWordIn, .rawDataIn, .regWr, .regRd, .videoModePinOut,
  .videoModePinOe, .descrambleEnable, .featureEnable, .doutSecond, .doutOe,
  .serialLoopOutputOe, .testSeqReset_n, .regRdata
);
`default_nettype wire

// *** dv/rmo_mode_ctrl_bench.sv ***
// Self-checking bench for the mode and output control block.
// Assumes the sink model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module rmo_mode_ctrl_bench
  import rmo_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals, named as the ports
  logic mclk = 0, arst_n = 1, busWidthSelect = 0, processingEnablePin = 1;
  logic asyncTransportModePin = 0, rateSelect = 0, masterModePin = 1, testModePin = 1;
  logic vidDrv = 0, coreLockedSmpte = 0, coreLockedAsi = 0, regWr = 0, regRd = 0;
  logic [ADDR_W-1:0] regAddr = 4'h0;
  logic [DATA_W-1:0] regWdata = 16'h0000;
  logic [WORD_W-1:0] primaryWordIn = 10'h0f0, chromaWordIn = 10'h2a5;
  logic [2*WORD_W-1:0] rawDataIn = {10'h155, 10'h0aa};
  logic videoModePinOut, videoModePinOe, descrambleEnable, smpteAlignEnable;
  logic asiDecodeEnable, doutOe, serialLoopOutputOe, testSeqReset_n;
  logic [FEAT_N-1:0] featureEnable;
  logic [WORD_W-1:0] doutFirst, doutSecond, seenFirst, seenSecond;
  logic [DATA_W-1:0] regRdata;
  wire logic videoModePinIn;
  int nErrors = 0, checked = 0;
  // Pin level: the device's driver wins while enabled
  assign videoModePinIn = videoModePinOe ? videoModePinOut : vidDrv;
  always #5 mclk = ~mclk;
  rmo_mode_ctrl i_dut (
    .mclk, .arst_n, .busWidthSelect, .processingEnablePin, .asyncTransportModePin,
    .rateSelect, .masterModePin, .testModePin, .videoModePinIn, .videoModePinOut,
    .videoModePinOe, .coreLockedSmpte, .coreLockedAsi, .primaryWordIn, .chromaWordIn,
    .rawDataIn, .descrambleEnable, .smpteAlignEnable, .asiDecodeEnable, .featureEnable,
    .doutFirst, .doutSecond, .doutOe, .serialLoopOutputOe, .testSeqReset_n,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata
  );
  rmo_sink_model i_sink (.mclk, .doutFirst, .doutSecond, .seenFirst, .seenSecond);
  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    checked++;
    if (g !== e)
    begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    if (nErrors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Long enough for the checker's quiet counter to arm before inputs move again
  task automatic settle;
    repeat (20) @(posedge mclk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge mclk);
    regWr <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge mclk);
    regRd <= 1'h0;
    #1 chk("regRdata", e, regRdata);
    @(posedge mclk);
  endtask
  task automatic doReset;
    arst_n <= 1'h0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'h1;
    settle();
  endtask
  // ==========================================================
  // Watchdog, far beyond the roughly 560 cycles the tests need
  initial
  begin
    #100000;
    nErrors++;
    complete_run();
  end
  // ==========================================================
  // Tests
  initial
  begin
    logic [WORD_W-1:0] exp;
    logic [FEAT_N-1:0] fx;
    // A real falling edge, so the asynchronous reset takes hold before the first clock
    arst_n <= 1'h0;
    repeat (8) @(posedge mclk);
    chk("doutOe", 1'h0, doutOe);
    chk("modeOe", 1'h0, videoModePinOe);
    chk("loopOe", 1'h0, serialLoopOutputOe);
    chk("testRst", 1'h0, testSeqReset_n);
    arst_n <= 1'h1;
    settle();
    chk("testRst", 1'h1, testSeqReset_n);
    chk("doutOe", 1'h1, doutOe);
    chk("loopOe", 1'h1, serialLoopOutputOe);
    masterModePin <= 1'h0;
    testModePin <= 1'h0;
    // Every width, mode and rate combination, reset after each rate change
    for (int r = 0; r < 2; r++)
    begin
      rateSelect <= r[0];
      doReset();
      for (int m = 0; m < 8; m++)
      begin
        {busWidthSelect, vidDrv, asyncTransportModePin} <= m[2:0];
        settle();
        exp = (m[1:0] == 2'h2) ? chromaWordIn : rawDataIn[2*WORD_W-1:WORD_W];
        if (!m[2] || m[0])
          exp = 10'h000;
        fx = (m[1:0] != 2'h2) ? 6'h00 : r[0] ? ~FEAT_HD_ONLY : ~FEAT_SD_ONLY;
        chk("second", exp, seenSecond);
        chk("descramble", m[1:0] == 2'h2, descrambleEnable);
        chk("align", m[1:0] == 2'h2, smpteAlignEnable);
        exp = (m[1:0] == 2'h0) ? rawDataIn[WORD_W-1:0] : primaryWordIn;
        chk("first", exp, seenFirst);
        chk("asiDecode", m[1:0] == 2'h1, asiDecodeEnable);
        chk("features", fx, featureEnable);
      end
    end
    // Per-feature disable while enabled, then the enable pin overrides it
    {busWidthSelect, vidDrv, asyncTransportModePin} <= 3'h6;
    wr(REG_FEAT_DIS, 16'h0012);
    rd(REG_FEAT_DIS, 16'h0012);
    settle();
    fx = ~FEAT_HD_ONLY & ~6'h12;
    chk("features", fx, featureEnable);
    coreLockedAsi <= 1'h1;
    wr(REG_STATUS, 16'hffff);
    rd(REG_STATUS, 16'h25e1);
    rd(4'hc, 16'h0000);
    processingEnablePin <= 1'h0;
    settle();
    chk("features", 6'h00, featureEnable);
    rd(REG_CONFIG, 16'h0001);
    wr(REG_CONFIG, 16'h0000);
    rd(REG_CONFIG, 16'h0000);
    chk("loopOe", 1'h0, serialLoopOutputOe);
    // Master mode drives the pin from the lock state
    masterModePin <= 1'h1;
    coreLockedSmpte <= 1'h1;
    settle();
    chk("modeOe", 1'h1, videoModePinOe);
    chk("modeOut", 1'h1, videoModePinOut);
    chk("second", chromaWordIn, seenSecond);
    coreLockedSmpte <= 1'h0;
    settle();
    chk("modeOut", 1'h0, videoModePinOut);
    masterModePin <= 1'h0;
    settle();
    chk("modeOe", 1'h0, videoModePinOe);
    // Reset in test mode holds then releases the test sequence
    testModePin <= 1'h1;
    settle();
    chk("testRst", 1'h1, testSeqReset_n);
    arst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    chk("testRst", 1'h0, testSeqReset_n);
    chk("doutOe", 1'h0, doutOe);
    arst_n <= 1'h1;
    settle();
    chk("testRst", 1'h1, testSeqReset_n);
    rd(REG_FEAT_DIS, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire

// *** dv/rmo_sink_model.sv ***
// Downstream logic that samples the receiver's parallel bus.
// Assumes the bus is clocked by mclk, which is also the pixel clock.
`timescale 1ns/1ns
`default_nettype none
module rmo_sink_model
  import rmo_pkg::*;
(
  // Pixel clock
  input wire logic mclk,
  // Parallel bus from the receiver
  input wire logic [WORD_W-1:0] doutFirst,
  input wire logic [WORD_W-1:0] doutSecond,
  // Words as captured downstream
  output logic [WORD_W-1:0] seenFirst,
  output logic [WORD_W-1:0] seenSecond
);
  // ==========================================================
  // Capture
  // One flop per word; a bus not launched on this clock would smear here
  always_ff @(posedge mclk)
  begin
    seenFirst <= doutFirst;
    seenSecond <= doutSecond;
  end
endmodule
`default_nettype wire

// *** verilog/rmo_mode_ctrl.sv ***
// Mode and parallel output control for a serial video receiver.
// Assumes mclk is the pixel clock and core data arrive synchronous to it.
// What this block does
// - Second word bus, bit 9 MSB, clocked
// - Width pin picks 20 or 10 bit
// - Ten bit arrangement forces second word low
// - Twenty bit SMPTE puts chroma on second
// - Twenty bit data-through passes raw data
// - SD twenty bit ASYNC_TRANSPORT_MODE_PIN forces second low
// - Processing enable pin turns features on
// - Six features, some gated by rate
// - Software disables features individually by register
// - Enable pin low kills every feature
// - Video mode pin input slave, output master
// - Master drives pin high only when locked
// - Slave pin high, ASI low: SMPTE mode
// - Slave pin low: no SMPTE, no features
// - Host reset: defaults, all pins released
// - Test reset holds test sequence reset
// - Test reset release resumes test sequence
// - ASI pin low: no ASI decode
`timescale 1ns/1ns
`default_nettype none
module rmo_mode_ctrl
  import rmo_pkg::*;
#(
  parameter int WORD = WORD_W
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Control pins from the application layer
  input wire logic busWidthSelect,
  input wire logic processingEnablePin,
  input wire logic asyncTransportModePin,
  input wire logic rateSelect,
  input wire logic masterModePin,
  input wire logic testModePin,
  // Video mode two-way pin
  input wire logic videoModePinIn,
  output logic videoModePinOut,
  output logic videoModePinOe,
  // Receiver core
  input wire logic coreLockedSmpte,
  input wire logic coreLockedAsi,
  input wire logic [WORD-1:0] primaryWordIn,
  input wire logic [WORD-1:0] chromaWordIn,
  input wire logic [2*WORD-1:0] rawDataIn,
  // Core steering
  output logic descrambleEnable,
  output logic smpteAlignEnable,
  output logic asiDecodeEnable,
  output logic [FEAT_N-1:0] featureEnable,
  // Parallel output bus
  output logic [WORD-1:0] doutFirst,
  output logic [WORD-1:0] doutSecond,
  output logic doutOe,
  output logic serialLoopOutputOe,
  // Test access sequence
  output logic testSeqReset_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdata
);
  // ==========================================================
  // Elaboration check
  if (WORD != WORD_W)
  begin : gChk
    $error("rmo_mode_ctrl supports only ten-bit output words");
  end

  // ==========================================================
  // Pin synchronisation
  logic [PIN_N-1:0] pinRaw;
  logic [PIN_N-1:0] pinSync;
  logic width20;
  logic procEn;
  logic videoPinSync;
  logic asiPin;
  logic rateSd;
  logic masterMode;
  logic testMode;

  // Pack raw pins for the synchroniser bank
  always_comb
  begin
    pinRaw = '0;
    pinRaw[PIN_WIDTH] = busWidthSelect;
    pinRaw[PIN_PROC] = processingEnablePin;
    pinRaw[PIN_VIDEO] = videoModePinIn;
    pinRaw[PIN_ASI] = asyncTransportModePin;
    pinRaw[PIN_RATE] = rateSelect;
    pinRaw[PIN_MASTER] = masterModePin;
    pinRaw[PIN_TEST] = testModePin;
  end

  // Every asynchronous pin is filtered before it steers anything
  rmo_pin_sync #(
    .WIDTH(PIN_N)
  ) uSync (
    .mclk(mclk),
    .arst_n(arst_n),
    .pinIn(pinRaw),
    .pinOut(pinSync)
  );

  // Named views of the filtered pins
  assign width20 = pinSync[PIN_WIDTH];
  assign procEn = pinSync[PIN_PROC];
  assign videoPinSync = pinSync[PIN_VIDEO];
  assign asiPin = pinSync[PIN_ASI];
  assign rateSd = pinSync[PIN_RATE];
  assign masterMode = pinSync[PIN_MASTER];
  assign testMode = pinSync[PIN_TEST];

  // ==========================================================
  // Helper functions

  // Drop features that do not exist at the current rate
  function automatic logic [FEAT_N-1:0] rateGate(input logic sd, input logic [FEAT_N-1:0] f);
    logic [FEAT_N-1:0] g;
    g = f;
    if (sd)
    begin
      g = f & ~FEAT_HD_ONLY;
    end
    else
    begin
      g = f & ~FEAT_SD_ONLY;
    end
    return g;
  endfunction

  // Register address match
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  // ==========================================================
  // Registers
  logic [FEAT_N-1:0] featDis_r;
  logic [FEAT_N-1:0] featDis_nxt;
  logic [DATA_W-1:0] cfg_r;
  logic [DATA_W-1:0] cfg_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] statusWord;

  // ==========================================================
  // Mode decision
  rmo_mode_t mode_r;
  rmo_mode_t mode_nxt;
  logic videoSel;
  logic [FEAT_N-1:0] feat_r;
  logic [FEAT_N-1:0] feat_nxt;
  logic descr_r;
  logic descr_nxt;
  logic asiDec_r;
  logic asiDec_nxt;

  // The pin is our output in master mode, otherwise the application's
  assign videoSel = masterMode ? coreLockedSmpte : videoPinSync;

  // Mode and core steering
  always_comb
  begin
    mode_nxt = MODE_IDLE;
    descr_nxt = 1'b0;
    asiDec_nxt = 1'b0;
    if (videoSel && !asiPin)
    begin
      mode_nxt = MODE_SMPTE;
      descr_nxt = 1'b1;
    end
    else if (!videoSel && asiPin)
    begin
      mode_nxt = MODE_ASI;
      asiDec_nxt = 1'b1;
    end
    else if (!videoSel && !asiPin)
    begin
      mode_nxt = MODE_THRU;
    end
  end

  // Features: pin, SMPTE mode, rate and per-feature disable all gate
  always_comb
  begin
    feat_nxt = '0;
    if (procEn && mode_nxt == MODE_SMPTE)
    begin
      feat_nxt = rateGate(rateSd, ~featDis_r);
    end
  end

  // Register mode and steering
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_r <= MODE_IDLE;
      feat_r <= '0;
      descr_r <= 1'b0;
      asiDec_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      feat_r <= feat_nxt;
      descr_r <= descr_nxt;
      asiDec_r <= asiDec_nxt;
    end
  end

  assign descrambleEnable = descr_r;
  assign smpteAlignEnable = descr_r;
  assign asiDecodeEnable = asiDec_r;
  assign featureEnable = feat_r;

  // ==========================================================
  // Parallel output path
  logic [WORD-1:0] first_r;
  logic [WORD-1:0] first_nxt;
  logic [WORD-1:0] second_r;
  logic [WORD-1:0] second_nxt;

  // Word selection; ASI and undefined pin combinations give a quiet second word
  always_comb
  begin
    first_nxt = primaryWordIn;
    second_nxt = '0;
    if (width20)
    begin
      unique case (mode_r)
        MODE_SMPTE: second_nxt = chromaWordIn;
        MODE_THRU:
        begin
          first_nxt = rawDataIn[WORD-1:0];
          second_nxt = rawDataIn[2*WORD-1:WORD];
        end
        MODE_ASI: second_nxt = '0;
        MODE_IDLE: second_nxt = '0;
      endcase
    end
    else
    begin
      second_nxt = '0;
      if (mode_r == MODE_THRU)
      begin
        first_nxt = rawDataIn[WORD-1:0];
      end
    end
  end

  // Output words on the pixel clock
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      first_r <= '0;
      second_r <= '0;
    end
    else
    begin
      first_r <= first_nxt;
      second_r <= second_nxt;
    end
  end

  assign doutFirst = first_r;
  assign doutSecond = second_r;

  // ==========================================================
  // Pin drive and test sequence reset
  logic run_r;
  logic vpOut_r;
  logic vpOut_nxt;
  logic vpOe_r;
  logic vpOe_nxt;
  logic tstRst_r;
  logic tstRst_nxt;

  // Master drive follows SMPTE lock only
  always_comb
  begin
    vpOut_nxt = masterMode && coreLockedSmpte;
    vpOe_nxt = masterMode;
    tstRst_nxt = testMode;
  end

  // Everything stays released until the clock after reset lifts
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_r <= 1'b0;
      vpOut_r <= 1'b0;
      vpOe_r <= 1'b0;
      tstRst_r <= 1'b0;
    end
    else
    begin
      run_r <= 1'b1;
      vpOut_r <= vpOut_nxt;
      vpOe_r <= vpOe_nxt;
      tstRst_r <= tstRst_nxt;
    end
  end

  assign videoModePinOut = vpOut_r;
  assign videoModePinOe = vpOe_r && run_r;
  assign doutOe = run_r;
  assign serialLoopOutputOe = run_r && cfg_r[CFG_LOOP_EN];
  assign testSeqReset_n = tstRst_r;

  // ==========================================================
  // Register port

  // Status snapshot of the block's own state
  always_comb
  begin
    statusWord = '0;
    statusWord[ST_FEAT_LSB +: FEAT_N] = feat_r;
    statusWord[ST_WIDTH20] = width20;
    statusWord[ST_PROC_EN] = procEn;
    statusWord[ST_MODE_LSB +: 2] = mode_r;
    statusWord[ST_LOCKED] = coreLockedSmpte || coreLockedAsi;
    statusWord[ST_MASTER] = masterMode;
    statusWord[ST_TEST] = testMode;
    statusWord[ST_RATE_SD] = rateSd;
  end

  // Writes and reads; data stand only in the cycle after the read
  always_comb
  begin
    featDis_nxt = featDis_r;
    cfg_nxt = cfg_r;
    rdata_nxt = '0;
    if (regWr)
    begin
      if (hit(regAddr, REG_FEAT_DIS))
      begin
        featDis_nxt = regWdata[FEAT_N-1:0];
      end
      if (hit(regAddr, REG_CONFIG))
      begin
        cfg_nxt = '0;
        cfg_nxt[CFG_LOOP_EN] = regWdata[CFG_LOOP_EN];
      end
    end
    if (regRd)
    begin
      if (hit(regAddr, REG_FEAT_DIS))
      begin
        rdata_nxt[FEAT_N-1:0] = featDis_r;
      end
      else if (hit(regAddr, REG_STATUS))
      begin
        rdata_nxt = statusWord;
      end
      else if (hit(regAddr, REG_CONFIG))
      begin
        rdata_nxt = cfg_r;
      end
    end
  end

  // Register file state
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      featDis_r <= FEAT_DIS_RST;
      cfg_r <= CFG_RST;
      rdata_r <= '0;
    end
    else
    begin
      featDis_r <= featDis_nxt;
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign regRdata = rdata_r;
endmodule
`default_nettype wire

// *** verilog/rmo_pin_sync.sv ***
// Bank of three-stage synchronisers for asynchronous control pins.
// Assumes the pins are static or slow compared to the clock.
`timescale 1ns/1ns
`default_nettype none
module rmo_pin_sync
  import rmo_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Raw pins and filtered levels
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  // ==========================================================
  // Elaboration check
  if (WIDTH < 1)
  begin : gChk
    $error("rmo_pin_sync needs WIDTH of at least one");
  end

  // ==========================================================
  // Stages
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] out_r;
  logic [WIDTH-1:0] out_nxt;

  // Only stages two and three are compared; stage one may be metastable
  always_comb
  begin
    out_nxt = out_r;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_r[i] == s3_r[i])
      begin
        out_nxt[i] = s3_r[i];
      end
    end
  end

  // Register all stages
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end
    else
    begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign pinOut = out_r;
endmodule
`default_nettype wire

// *** verilog/rmo_pkg.sv ***
// Shared constants for the receiver mode and output control block.
// Assumes a single 100 MHz clock that also serves as the pixel output clock.
package rmo_pkg;
  // ==========================================================
  // Register bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_FEAT_DIS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h8;
  // ==========================================================
  // Processing feature bit positions
  localparam int FEAT_N = 6;
  localparam int FEAT_EDH = 0;
  localparam int FEAT_ANC = 1;
  localparam int FEAT_LCRC = 2;
  localparam int FEAT_LNUM = 3;
  localparam int FEAT_TRS = 4;
  localparam int FEAT_ICR = 5;
  localparam logic [FEAT_N-1:0] FEAT_DIS_RST = 6'h00;
  // Features that exist only at one rate
  localparam logic [FEAT_N-1:0] FEAT_SD_ONLY = 6'h01;
  localparam logic [FEAT_N-1:0] FEAT_HD_ONLY = 6'h0c;
  // ==========================================================
  // Status register fields
  localparam int ST_FEAT_LSB = 0;
  localparam int ST_WIDTH20 = 6;
  localparam int ST_PROC_EN = 7;
  localparam int ST_MODE_LSB = 8;
  localparam int ST_LOCKED = 10;
  localparam int ST_MASTER = 11;
  localparam int ST_TEST = 12;
  localparam int ST_RATE_SD = 13;
  // Config register fields
  localparam int CFG_LOOP_EN = 0;
  localparam logic [DATA_W-1:0] CFG_RST = 16'h0001;
  // ==========================================================
  // Word width and pin synchroniser
  localparam int WORD_W = 10;
  localparam int PIN_N = 7;
  localparam int PIN_WIDTH = 0;
  localparam int PIN_PROC = 1;
  localparam int PIN_VIDEO = 2;
  localparam int PIN_ASI = 3;
  localparam int PIN_RATE = 4;
  localparam int PIN_MASTER = 5;
  localparam int PIN_TEST = 6;
  // Operating modes
  typedef enum logic [1:0] {MODE_IDLE, MODE_SMPTE, MODE_THRU, MODE_ASI} rmo_mode_t;
endpackage
